//--- pprpc_defs.svh
// Register map and field positions of the pin control block.
// Assumes a 32-bit classic Wishbone bus; each register is one aligned word.
`ifndef PPRPC_DEFS_SVH
`define PPRPC_DEFS_SVH

// Word indices; the byte address is four times the index.
`define PPRPC_IDX_STATUS   2'h0
`define PPRPC_IDX_FUNC     2'h1
`define PPRPC_IDX_READ     2'h2
`define PPRPC_IDX_PINSTATE 2'h3

// Status register fields.
`define PPRPC_SR_SWD      7
`define PPRPC_SR_QE       6
`define PPRPC_SR_BP_HI    5
`define PPRPC_SR_BP_LO    2
`define PPRPC_SR_WEL      1
`define PPRPC_SR_BUSY     0
`define PPRPC_SR_RESET    8'h00

// Function register: dedicated reset disable.
`define PPRPC_FR_DRST_DIS 0
`define PPRPC_FR_RESET    8'h00

// Read register: pause/reset select.
`define PPRPC_RR_PRS      7
`define PPRPC_RR_RESET    8'h00

// Pin state register fields.
`define PPRPC_PS_PAUSED   0
`define PPRPC_PS_INRST    1
`define PPRPC_PS_WPROT    2
`define PPRPC_PS_REFUSED  6

`endif

//--- pprpc_pkg.sv
// Types shared by the pin control block and its role selector.
// Assumes nothing of its surroundings.
package pprpc_pkg;

  // Function of the shared fourth data line.
  typedef enum logic [2:0] {
    ROLE_PAUSE = 3'b001,
    ROLE_RESET = 3'b010,
    ROLE_QUAD  = 3'b100
  } pprpc_role_t;

endpackage

//--- pprpc_role_if.sv
// Carrier between the pin control top and its role selector.
// Assumes both ends share core_clk.
`timescale 1ns/10ps
interface pprpc_role_if;
  logic                   quad_en;
  logic                   ded_rst_en;
  logic                   prs;
  pprpc_pkg::pprpc_role_t role;

  modport ctl (output quad_en, output ded_rst_en, output prs, input role);
  modport sel (input quad_en, input ded_rst_en, input prs, output role);
endinterface

//--- pprpc_role_sel.sv
// Role selector for the shared fourth data line.
// Assumes control bits arrive from registers on core_clk.
`timescale 1ns/10ps
module pprpc_role_sel #(
  parameter bit HAS_DED_RST = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic rst,
  pprpc_role_if.sel rif
);

  pprpc_pkg::pprpc_role_t role_ff;
  pprpc_pkg::pprpc_role_t nxt_role;
  wire                    follow_prs;

  // With the dedicated reset pin live, the select bit has no say.
  assign follow_prs = !HAS_DED_RST || !rif.ded_rst_en;  // RULE_06 RULE_07
  assign nxt_role   = rif.quad_en ? pprpc_pkg::ROLE_QUAD :  // RULE_04
                      (follow_prs && rif.prs) ? pprpc_pkg::ROLE_RESET :  // RULE_05 RULE_07
                      pprpc_pkg::ROLE_PAUSE;  // RULE_05 RULE_06

  always_ff @(posedge core_clk) begin
    if (rst) begin
      role_ff <= pprpc_pkg::ROLE_PAUSE;
    end else begin
      role_ff <= nxt_role;
    end
  end

  assign rif.role = role_ff;

endmodule

//--- pprpc_pin_ctrl.sv
// Shared pin control of a serial flash: status write protection, pause,
// hardware reset and quad data line hand-over.
// Assumes pins and the serial clock are sampled synchronously on core_clk.
`timescale 1ns/10ps
`include "pprpc_defs.svh"

// Notes on behaviour
// (RULE_01) Protect pin low plus disable bit blocks writes.
// (RULE_02) Disable bit clear: status writes always allowed.
// (RULE_03) Quad mode turns protect pin into data line.
// (RULE_04) Quad mode turns pause/reset pin into data.
// (RULE_05) No dedicated pin: select bit picks pause/reset.
// (RULE_06) Dedicated reset enabled: shared pin is pause.
// (RULE_07) Dedicated reset disabled: select bit picks function.
// (RULE_08) Pause only while selected, keeps partial command.
// (RULE_09) Paused and selected: serial output goes high-impedance.
// (RULE_10) Transfer resumes where it stopped after pause.
// (RULE_11) Reset low: held in reset, outputs high-impedance.
// (RULE_12) Function bit 0 set disables dedicated reset.
// (RULE_13) Host avoids reset during internal write operations.
// (RULE_14) Quad enable is status bit 6, default 0.
// (RULE_15) While paused, serial clock edges are ignored.
module pprpc_pin_ctrl #(
  parameter bit HAS_DED_RST = 1'b1
) (
  input  wire  logic        core_clk,
  input  wire  logic        rst,
  input  wire  logic [3:0]  wb_adr_i,
  input  wire  logic [31:0] wb_dat_i,
  output logic       [31:0] wb_dat_o,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic        wb_we_i,
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  output logic              wb_ack_o,
  input  wire  logic        cs_n_i,
  input  wire  logic        sck_i,
  input  wire  logic        si_i,
  output logic              so_o,
  output logic              so_oe,
  input  wire  logic        data_line_2_i,
  output logic              data_line_2_o,
  output logic              data_line_2_oe,
  input  wire  logic        data_line_3_i,
  output logic              data_line_3_o,
  output logic              data_line_3_oe,
  input  wire  logic        reset_n_i,
  input  wire  logic        core_so_i,
  input  wire  logic        core_so_en_i,
  input  wire  logic        core_d2_i,
  input  wire  logic        core_d2_en_i,
  input  wire  logic        core_d3_i,
  input  wire  logic        core_d3_en_i,
  input  wire  logic        core_busy_i,
  output logic              core_shift_o,
  output logic              core_paused_o,
  output logic              core_reset_o,
  output logic              core_quad_o,
  output logic [1:0]        core_quad_in_o,
  output logic [3:0]        block_protect_o,
  output logic [7:0]        cmd_byte_o,
  output logic              cmd_valid_o
);

  pprpc_role_if rif ();

  pprpc_role_sel #(
    .HAS_DED_RST (HAS_DED_RST)
  ) u_role_sel (
    .core_clk (core_clk),
    .rst      (rst),
    .rif      (rif)
  );

  logic [7:0]  status_ff;
  logic [7:0]  func_ff;
  logic [7:0]  rdreg_ff;
  logic        refused_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        sck_prev_ff;
  logic [2:0]  bit_cnt_ff;
  logic [7:0]  shreg_ff;
  logic        shift_ff;
  logic        paused_ff;
  logic        inrst_ff;
  logic        so_ff;
  logic        so_oe_ff;
  logic        dl2_ff;
  logic        dl2_oe_ff;
  logic        dl3_ff;
  logic        dl3_oe_ff;
  logic [1:0]  quad_in_ff;
  logic [7:0]  cmd_ff;
  logic        cmd_valid_ff;

  logic [7:0]  nxt_status;
  logic [7:0]  nxt_func;
  logic [7:0]  nxt_rdreg;
  logic        nxt_refused;
  logic [2:0]  nxt_bit_cnt;
  logic [7:0]  nxt_shreg;

  wire         qe;
  wire         wp_protect;
  wire         role_pause;
  wire         role_reset;
  wire         role_quad;
  wire         ded_rst_act;
  wire         shr_rst_act;
  wire         hw_reset;
  wire         pause_now;
  wire         sck_rise;
  wire         accept;
  wire         byte_done;
  wire         bus_req;
  wire         bus_wr;
  wire         wr_status;
  wire         wr_func;
  wire         wr_rdreg;
  wire         wr_pinst;
  wire         refuse_ev;
  wire [7:0]   wr_byte;
  wire [7:0]   prot_mask;
  wire [7:0]   pin_state;
  wire [31:0]  rd_word;

  // Control bits handed to the role selector.
  assign qe             = status_ff[`PPRPC_SR_QE];  // RULE_14
  assign rif.quad_en    = qe;
  assign rif.ded_rst_en = !func_ff[`PPRPC_FR_DRST_DIS];
  assign rif.prs        = rdreg_ff[`PPRPC_RR_PRS];
  assign role_pause     = (rif.role == pprpc_pkg::ROLE_PAUSE);
  assign role_reset     = (rif.role == pprpc_pkg::ROLE_RESET);
  assign role_quad      = (rif.role == pprpc_pkg::ROLE_QUAD);

  // In quad mode the third line carries data, so its level never protects.
  assign wp_protect  = status_ff[`PPRPC_SR_SWD] && !qe && !data_line_2_i;  // RULE_01 RULE_02 RULE_03

  assign ded_rst_act = HAS_DED_RST && !func_ff[`PPRPC_FR_DRST_DIS] && !reset_n_i;  // RULE_11 RULE_12
  assign shr_rst_act = role_reset && !data_line_3_i;  // RULE_05 RULE_07
  assign hw_reset    = ded_rst_act || shr_rst_act;  // RULE_11

  // Pause counts only while the chip is selected.
  assign pause_now = role_pause && !data_line_3_i && !cs_n_i;  // RULE_08
  assign sck_rise  = sck_i && !sck_prev_ff;
  assign accept    = sck_rise && !cs_n_i && !pause_now && !hw_reset;  // RULE_15 RULE_10
  assign byte_done = accept && (bit_cnt_ff == 3'h7);

  // Bus decode; a write lands on the edge where ack is seen high.
  assign bus_req   = wb_cyc_i && wb_stb_i;
  assign bus_wr    = bus_req && wb_we_i && ack_ff && wb_sel_i[0];
  assign wr_byte   = wb_dat_i[7:0];
  assign wr_status = bus_wr && (wb_adr_i[3:2] == `PPRPC_IDX_STATUS);
  assign wr_func   = bus_wr && (wb_adr_i[3:2] == `PPRPC_IDX_FUNC);
  assign wr_rdreg  = bus_wr && (wb_adr_i[3:2] == `PPRPC_IDX_READ);
  assign wr_pinst  = bus_wr && (wb_adr_i[3:2] == `PPRPC_IDX_PINSTATE);

  // Protected bits keep their value; the write latch stays writable.
  assign prot_mask = wp_protect ? 8'h02 : 8'hfe;  // RULE_01 RULE_02 RULE_03
  assign refuse_ev = wr_status && wp_protect;  // RULE_01

  assign nxt_status = hw_reset ? {status_ff[7:2], 2'b00} :
                      wr_status ? ((wr_byte & prot_mask) | (status_ff & ~prot_mask)) :
                      status_ff;
  assign nxt_func   = wr_func ? wr_byte : func_ff;  // RULE_12
  assign nxt_rdreg  = wr_rdreg ? wr_byte : rdreg_ff;  // RULE_05 RULE_07

  // A refusal in the same cycle as a clear still sets the flag.
  assign nxt_refused = refuse_ev || (refused_ff && !(wr_pinst && wr_byte[`PPRPC_PS_REFUSED]));

  // Pin state is read only; a write there can only clear the refused flag.
  assign pin_state = {1'b0, refused_ff, rif.role, wp_protect, inrst_ff, paused_ff};
  assign rd_word   = (wb_adr_i[3:2] == `PPRPC_IDX_STATUS)   ?
                       {24'h000000, status_ff[7:1], core_busy_i} :
                     (wb_adr_i[3:2] == `PPRPC_IDX_FUNC)     ? {24'h000000, func_ff} :
                     (wb_adr_i[3:2] == `PPRPC_IDX_READ)     ? {24'h000000, rdreg_ff} :
                     {24'h000000, pin_state};

  // Partial command survives a pause; only deselect or reset clears it.
  assign nxt_bit_cnt = (cs_n_i || hw_reset) ? 3'h0 :
                       accept ? bit_cnt_ff + 3'h1 : bit_cnt_ff;  // RULE_08 RULE_10
  assign nxt_shreg   = (cs_n_i || hw_reset) ? 8'h00 :
                       accept ? {shreg_ff[6:0], si_i} : shreg_ff;  // RULE_15

  // Hardware reset spares bits 7:2, which stand for cells that keep their value.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_ff  <= `PPRPC_SR_RESET;
      func_ff    <= `PPRPC_FR_RESET;
      rdreg_ff   <= `PPRPC_RR_RESET;
      refused_ff <= 1'b0;
    end else begin
      status_ff  <= nxt_status;
      func_ff    <= nxt_func;
      rdreg_ff   <= nxt_rdreg;
      refused_ff <= nxt_refused;
    end
  end

  // Every access answers one cycle after it is raised, mapped or not.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req && !ack_ff;
      dat_ff <= (bus_req && !ack_ff) ? rd_word : dat_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_prev_ff  <= 1'b0;
      bit_cnt_ff   <= 3'h0;
      shreg_ff     <= 8'h00;
      shift_ff     <= 1'b0;
      cmd_ff       <= 8'h00;
      cmd_valid_ff <= 1'b0;
    end else begin
      sck_prev_ff  <= sck_i;
      bit_cnt_ff   <= nxt_bit_cnt;
      shreg_ff     <= nxt_shreg;
      shift_ff     <= accept;  // RULE_15
      cmd_ff       <= byte_done ? {shreg_ff[6:0], si_i} : cmd_ff;
      cmd_valid_ff <= byte_done;
    end
  end

  // Pin drivers are registered, so enables lag the pins by one cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      paused_ff  <= 1'b0;
      inrst_ff   <= 1'b0;
      so_ff      <= 1'b0;
      so_oe_ff   <= 1'b0;
      dl2_ff     <= 1'b0;
      dl2_oe_ff  <= 1'b0;
      dl3_ff     <= 1'b0;
      dl3_oe_ff  <= 1'b0;
      quad_in_ff <= 2'h0;
    end else begin
      paused_ff  <= pause_now;  // RULE_08
      inrst_ff   <= hw_reset;  // RULE_11
      so_ff      <= core_so_i;
      so_oe_ff   <= core_so_en_i && !cs_n_i && !pause_now && !hw_reset;  // RULE_09 RULE_11
      dl2_ff     <= core_d2_i;
      dl2_oe_ff  <= role_quad && core_d2_en_i && !cs_n_i && !hw_reset;  // RULE_03 RULE_11
      dl3_ff     <= core_d3_i;
      dl3_oe_ff  <= role_quad && core_d3_en_i && !cs_n_i && !hw_reset;  // RULE_04 RULE_11
      quad_in_ff <= role_quad ? {data_line_3_i, data_line_2_i} : 2'h0;  // RULE_04
    end
  end

  assign wb_ack_o        = ack_ff;
  assign wb_dat_o        = dat_ff;
  assign so_o            = so_ff;
  assign so_oe           = so_oe_ff;
  assign data_line_2_o   = dl2_ff;
  assign data_line_2_oe  = dl2_oe_ff;
  assign data_line_3_o   = dl3_ff;
  assign data_line_3_oe  = dl3_oe_ff;
  assign core_shift_o    = shift_ff;
  assign core_paused_o   = paused_ff;
  assign core_reset_o    = inrst_ff;
  assign core_quad_o     = qe;
  assign core_quad_in_o  = quad_in_ff;
  assign block_protect_o = status_ff[`PPRPC_SR_BP_HI:`PPRPC_SR_BP_LO];
  assign cmd_byte_o      = cmd_ff;
  assign cmd_valid_o     = cmd_valid_ff;

  // Checks run on core_clk and stand down while rst is high.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_prot_refuse: assert property (wr_status && wp_protect && !hw_reset |=>  // RULE_01
    status_ff[7:2] == $past(status_ff[7:2]))
    else $error("Protected status bits changed.");

  a_prot_allow: assert property (wr_status && !status_ff[`PPRPC_SR_SWD] && !hw_reset |=>  // RULE_02
    status_ff[7:2] == $past(wb_dat_i[7:2]))
    else $error("Unprotected status write was lost.");

  a_quad_nowp: assert property (wr_status && qe && !data_line_2_i && !hw_reset |=>  // RULE_03
    status_ff[7:2] == $past(wb_dat_i[7:2]))
    else $error("Quad mode still honoured the protect pin.");

  a_quad_role: assert property ($past(qe) && $past(qe, 2) |->  // RULE_04
    role_quad && !paused_ff && (!inrst_ff || $past(ded_rst_act)))
    else $error("Quad mode did not take the shared pin.");

  a_sel_reset: assert property (!qe && rif.prs && (!HAS_DED_RST || func_ff[0]) |=> role_reset)  // RULE_05 RULE_07
    else $error("Select bit did not pick the reset function.");

  a_ded_pause: assert property (HAS_DED_RST && !func_ff[0] && !qe |=> role_pause)  // RULE_06
    else $error("Shared pin left pause with dedicated reset live.");

  a_pause_keep: assert property (pause_now && !hw_reset |=> bit_cnt_ff == $past(bit_cnt_ff))  // RULE_08
    else $error("Pause disturbed the partial command.");

  a_pause_hiz: assert property (pause_now |=> !so_oe ##1 !so_oe || !$past(pause_now))  // RULE_09
    else $error("Serial output driven while paused.");

  a_resume: assert property (sck_rise && !cs_n_i && !pause_now && !hw_reset |=> core_shift_o)  // RULE_10
    else $error("Clock edge after pause was not taken.");

  a_reset_hiz: assert property (hw_reset |=> core_reset_o && !so_oe && !data_line_2_oe && !data_line_3_oe)  // RULE_11
    else $error("Outputs driven during hardware reset.");

  a_func_dis: assert property (func_ff[0] && !role_reset |=> !core_reset_o)  // RULE_12
    else $error("Disabled dedicated reset still acted.");

  a_pause_clk: assert property (pause_now |=> !core_shift_o)  // RULE_15
    else $error("Clock edge shifted while paused.");

  // Outside quad mode the spare lines stay released and their levels never reach core_quad_in_o.
  a_quad_lines: assert property (!role_quad |=>  // RULE_03 RULE_04
    !data_line_2_oe && !data_line_3_oe)
    else $error("Data line driven outside quad mode.");

  a_quad_capture: assert property (!role_quad |=>  // RULE_04
    core_quad_in_o == 2'h0)
    else $error("Quad inputs passed outside quad mode.");

  a_refuse_flag: assert property (refuse_ev |=>  // RULE_01
    refused_ff)
    else $error("Refused status write was not flagged.");

  // Pause and reset flags follow the pins one cycle late.
  a_pause_sel: assert property (cs_n_i |=>  // RULE_08
    !core_paused_o)
    else $error("Pause acted while deselected.");

  a_ded_reset: assert property (HAS_DED_RST && !func_ff[`PPRPC_FR_DRST_DIS] && !reset_n_i |=>  // RULE_11 RULE_12
    core_reset_o)
    else $error("Dedicated reset pin was not honoured.");

  a_shr_reset: assert property (role_reset && !data_line_3_i |=>  // RULE_05 RULE_07 RULE_11
    core_reset_o && !so_oe)
    else $error("Shared reset pin was not honoured.");

  a_shift_count: assert property (accept |=>  // RULE_10
    bit_cnt_ff == $past(bit_cnt_ff) + 3'h1)
    else $error("Accepted clock edge did not advance the bit count.");

endmodule

//--- pprpc_host_model.sv
// Host serial controller model: drives select, clock and data line 0.
// Assumes it shares core_clk with the pin block; clock idles low between bursts.
`timescale 1ns/10ps
module pprpc_host_model (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic       drop,
  input  wire logic       slow,
  input  wire logic [3:0] nb,
  input  wire logic [7:0] dat,
  output logic            cs_n,
  output logic            sck,
  output logic            si,
  output logic            busy
);
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [1:0] dly_ff;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
    busy = 1'b0;
  end
  always @(posedge core_clk) begin
    if (go && !busy) begin
      busy   <= 1'b1;
      cs_n   <= 1'b0;
      cnt_ff <= nb;
      sh_ff  <= dat;
      si     <= dat[7];
      dly_ff <= 2'h0;
    end else if (busy) begin
      dly_ff <= dly_ff + 2'h1;
      // A slow host holds each clock level four cycles, a quick one two.
      if (dly_ff == (slow ? 2'h3 : 2'h1)) begin
        dly_ff <= 2'h0;
        if (sck) begin
          sck    <= 1'b0;
          cnt_ff <= cnt_ff - 4'h1;
          sh_ff  <= {sh_ff[6:0], 1'b0};
          si     <= sh_ff[6];
        end else if (cnt_ff != 4'h0) begin
          sck <= 1'b1;
        end else begin
          busy <= 1'b0;
          cs_n <= drop;
          // Released line shows the inverse so stale data is never mistaken for a bit.
          si   <= ~si;
        end
      end
    end
  end
endmodule

//--- testbench.sv
// Self-checking bench for the shared pin control block.
// Assumes the design files and the host model are compiled before it.
`timescale 1ns/10ps
module testbench;
  logic        core_clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, so_o, so_oe;
  logic        wp_drv, hold_drv, reset_n_i, core_so_en_i, core_busy_i, cmd_valid_o;
  logic        data_line_2_o, data_line_2_oe, data_line_3_o, data_line_3_oe;
  logic        core_shift_o, core_paused_o, core_reset_o, core_quad_o;
  logic        cs_n, sck, si, h_go, h_drop, h_slow, h_busy, qd_en, so_drv;
  logic [1:0]  core_quad_in_o, cd;
  logic [3:0]  wb_adr_i, wb_sel_i, block_protect_o, h_nb;
  logic [7:0]  cmd_byte_o, h_dat, b, d;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int          n_errors, tests_run, n_shift, n_valid, seed;
  wire         dl2 = (data_line_2_oe === 1'b1) ? data_line_2_o : wp_drv;
  wire         dl3 = (data_line_3_oe === 1'b1) ? data_line_3_o : hold_drv;

  pprpc_pin_ctrl uut (.core_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o, .so_oe,
    .data_line_2_i(dl2), .data_line_2_o, .data_line_2_oe, .data_line_3_i(dl3), .data_line_3_o,
    .data_line_3_oe, .reset_n_i, .core_so_i(so_drv), .core_so_en_i, .core_d2_i(cd[0]),
    .core_d2_en_i(qd_en), .core_d3_i(cd[1]), .core_d3_en_i(qd_en), .core_busy_i, .core_shift_o,
    .core_paused_o, .core_reset_o, .core_quad_o, .core_quad_in_o, .block_protect_o,
    .cmd_byte_o, .cmd_valid_o);
  pprpc_host_model host (.core_clk, .go(h_go), .drop(h_drop), .slow(h_slow), .nb(h_nb),
    .dat(h_dat), .cs_n, .sck, .si, .busy(h_busy));

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (core_shift_o === 1'b1) n_shift <= n_shift + 1;
    if (cmd_valid_o === 1'b1) n_valid <= n_valid + 1;
  end

  task automatic summarize();
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] v);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, v};
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk("wb_ack_o", 32'h1, 32'(wb_ack_o));
    @(posedge core_clk);
  endtask
  task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask
  task automatic send(input logic [3:0] n, input logic [7:0] v, input logic dr);
    int k;
    h_nb   <= n;
    h_dat  <= v;
    h_drop <= dr;
    h_slow <= 1'($random(seed));
    h_go   <= 1'b1;
    @(posedge core_clk);
    h_go <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (h_busy === 1'b1 && k < 200);
    repeat (3) @(posedge core_clk);
  endtask
  // Dedicated reset pin present, so the select bit only counts once that pin is disabled.
  function automatic logic [31:0] exp_ps(input logic qe, input logic dis, input logic p);
    return {26'h0, qe ? 3'b100 : (dis && p) ? 3'b010 : 3'b001, 3'b000};
  endfunction

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    summarize();
  end

  initial begin
    seed = 32'hb9437746;
    rst = 1'b1;
    {wb_we_i, wb_cyc_i, wb_stb_i, core_busy_i, h_go, h_slow, qd_en, so_drv} = 8'h00;
    {wp_drv, hold_drv, reset_n_i, core_so_en_i, h_drop} = 5'h1f;
    {wb_adr_i, h_nb, h_dat, wb_dat_i, cd} = 50'h0;
    wb_sel_i = 4'h1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdchk("status", 4'h0, 32'h0);
    rdchk("function", 4'h4, 32'h0);
    rdchk("read reg", 4'h8, 32'h0);
    rdchk("pin state", 4'hc, 32'h08);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed)) & 8'h7e;
      wp_drv <= 1'($random(seed));
      core_busy_i <= 1'($random(seed));
      wb(1'b1, 4'h0, d);
      rdchk("status", 4'h1, {24'h0, d[7:1], core_busy_i});
      chk("block_protect_o", 32'(d[5:2]), 32'(block_protect_o));
      chk("core_quad_o", 32'(d[6]), 32'(core_quad_o));
    end
    core_busy_i <= 1'b0;
    wp_drv <= 1'b1;
    wb(1'b1, 4'h0, 8'h94);
    wp_drv <= 1'b0;
    wb(1'b1, 4'h0, 8'h2c);
    rdchk("status", 4'h0, 32'h94);
    rdchk("pin state", 4'hc, 32'h4c);
    wb(1'b1, 4'hc, 8'h40);
    rdchk("pin state", 4'hc, 32'h0c);
    wp_drv <= 1'b1;
    wb(1'b1, 4'h0, 8'hc0);
    rdchk("status", 4'h0, 32'hc0);
    wp_drv <= 1'b0;
    wb(1'b1, 4'h0, 8'h40);
    rdchk("status", 4'h0, 32'h40);
    for (int k = 0; k < 8; k++) begin
      wp_drv <= 1'($random(seed));
      wb(1'b1, 4'h0, {1'b0, k[2], 6'h0});
      // The shared pin goes free only once quad mode owns it; a low level could still reset.
      hold_drv <= k[2] ? 1'($random(seed)) : 1'b1;
      wb(1'b1, 4'h4, {7'h0, k[1]});
      wb(1'b1, 4'h8, {k[0], 7'h0});
      rdchk("pin state", 4'hc, exp_ps(k[2], k[1], k[0]));
      if (k[2]) chk("core_quad_in_o", 32'({dl3, dl2}), 32'(core_quad_in_o));
    end
    {wp_drv, hold_drv} <= 2'h3;
    wb(1'b1, 4'h0, 8'h00);
    wb(1'b1, 4'h4, 8'h00);
    wb(1'b1, 4'h8, 8'h00);
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      {n_shift, n_valid} = 64'h0;
      send(4'h8, b, 1'b1);
      chk("cmd_byte_o", 32'(b), 32'(cmd_byte_o));
      chk("valid count", 32'h1, n_valid);
    end
    b = 8'($random(seed));
    {n_shift, n_valid} = 64'h0;
    send(4'h4, b, 1'b0);
    chk("so_oe", 32'h1, 32'(so_oe));
    hold_drv <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("core_paused_o", 32'h1, 32'(core_paused_o));
    chk("so_oe", 32'h0, 32'(so_oe));
    send(4'h2, ~b, 1'b0);
    chk("shift count", 32'h4, n_shift);
    hold_drv <= 1'b1;
    repeat (3) @(posedge core_clk);
    send(4'h4, {b[3:0], 4'h0}, 1'b1);
    chk("cmd_byte_o", 32'(b), 32'(cmd_byte_o));
    chk("valid count", 32'h1, n_valid);
    hold_drv <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("core_paused_o", 32'h0, 32'(core_paused_o));
    hold_drv <= 1'b1;
    {qd_en, so_drv, cd} <= {1'b1, 1'($random(seed)), 1'b0, 1'($random(seed))};
    wb(1'b1, 4'h0, 8'h40);
    send(4'h0, 8'h00, 1'b0);
    chk("data_line_2_oe", 32'h1, 32'(data_line_2_oe));
    chk("data_line_2_o", 32'(cd[0]), 32'(data_line_2_o));
    chk("data_line_3_oe", 32'h1, 32'(data_line_3_oe));
    chk("data_line_3_o", 32'(cd[1]), 32'(data_line_3_o));
    chk("core_quad_in_o", 32'(cd), 32'(core_quad_in_o));
    chk("core_paused_o", 32'h0, 32'(core_paused_o));
    chk("so_o", 32'(so_drv), 32'(so_o));
    send(4'h0, 8'h00, 1'b1);
    wb(1'b1, 4'h0, 8'h06);
    send(4'h0, 8'h00, 1'b0);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("core_reset_o", 32'h1, 32'(core_reset_o));
    chk("so_oe", 32'h0, 32'(so_oe));
    reset_n_i <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdchk("status", 4'h0, 32'h04);
    wb(1'b1, 4'h4, 8'h01);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("core_reset_o", 32'h0, 32'(core_reset_o));
    wb(1'b1, 4'h8, 8'h80);
    hold_drv <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("core_reset_o", 32'h1, 32'(core_reset_o));
    {hold_drv, reset_n_i} <= 2'h3;
    send(4'h0, 8'h00, 1'b1);
    summarize();
  end
endmodule
